// ### intc.sv
// Two-level interrupt controller: latches, gates, prioritises, dispatches
// Holds the four control bytes, the flag sample and the running levels
// Assumes: flags and instruction status come from logic on core_clk
// Assumes: the core performs the call, pushing PC and not the status word
`include "intc_regs.svh"

module intc (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire intc_pkg::flag_in_t    flags,
  input  wire logic                  ext0_edge_mode,
  input  wire logic                  ext1_edge_mode,
  input  wire intc_pkg::instr_stat_t instr,
  input  wire logic                  ctrl_wr_en,
  input  wire logic [1:0]            ctrl_wr_sel,
  input  wire logic [7:0]            ctrl_wr_data,
  output logic [7:0]                 source_enable_low_bank,
  output logic [7:0]                 source_enable_high_bank,
  output logic [7:0]                 level_select_low_bank,
  output logic [7:0]                 level_select_high_bank,
  output intc_pkg::dispatch_t        dispatch,
  output logic                       ext0_flag_clear,
  output logic                       ext1_flag_clear,
  output logic [1:0]                 in_progress
);
  import intc_pkg::*;

  localparam int N = `SRC_COUNT;

  // Polling order and vector table below are written for eleven sources
  if (N != 11) begin : g_src_count_check
    $error("intc serves exactly eleven sources");
  end

  //////////////////////////////////////////////////////////////////////////
  // Control bytes written by firmware
  logic [7:0] en_lo_q;
  logic [7:0] en_hi_q;
  logic [7:0] lvl_lo_q;
  logic [7:0] lvl_hi_q;

  // Write strobe for one of the four control bytes
  function automatic logic wr_hit(input logic       en,
                                  input logic [1:0] sel,
                                  input logic [1:0] which);
    wr_hit = en && (sel == which);
  endfunction

  // Low enable bank; its top bit is the global gate
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_lo_q <= `EN_LO_RESET;
    end else if (wr_hit(ctrl_wr_en, ctrl_wr_sel, 2'd0)) begin
      en_lo_q <= ctrl_wr_data;
    end
  end

  // High enable bank
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_hi_q <= `EN_HI_RESET;
    end else if (wr_hit(ctrl_wr_en, ctrl_wr_sel, 2'd1)) begin
      en_hi_q <= ctrl_wr_data;
    end
  end

  // Low level bank; a set bit puts the source in the high level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lvl_lo_q <= `LVL_LO_RESET;
    end else if (wr_hit(ctrl_wr_en, ctrl_wr_sel, 2'd2)) begin
      lvl_lo_q <= ctrl_wr_data;
    end
  end

  // High level bank
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lvl_hi_q <= `LVL_HI_RESET;
    end else if (wr_hit(ctrl_wr_en, ctrl_wr_sel, 2'd3)) begin
      lvl_hi_q <= ctrl_wr_data;
    end
  end

  assign source_enable_low_bank  = en_lo_q;
  assign source_enable_high_bank = en_hi_q;
  assign level_select_low_bank   = lvl_lo_q;
  assign level_select_high_bank  = lvl_hi_q;

  //////////////////////////////////////////////////////////////////////////
  // Source requests in polling order, index 0 polled first
  logic [N-1:0] req;
  logic [N-1:0] en_vec;
  logic [N-1:0] hi_vec;

  // Gather a source-indexed vector from a low and a high control byte
  function automatic logic [N-1:0] pick(input logic [7:0] lo,
                                        input logic [7:0] hi);
    pick     = '0;
    pick[0]  = lo[`EN_LO_EXT0];
    pick[1]  = lo[`EN_LO_TMR0];
    pick[2]  = lo[`EN_LO_EXT1];
    pick[3]  = lo[`EN_LO_TMR1];
    pick[4]  = lo[`EN_LO_UART0];
    pick[5]  = lo[`EN_LO_TMR2];
    pick[6]  = hi[`EN_HI_SPI];
    pick[7]  = hi[`EN_HI_I2C];
    pick[8]  = hi[`EN_HI_ADC];
    pick[9]  = hi[`EN_HI_PCA];
    pick[10] = hi[`EN_HI_UART1];
  endfunction

  assign req = {flags.uart1_rx | flags.uart1_tx,
                flags.pca,
                flags.adc,
                flags.i2c,
                flags.spi,
                flags.tmr2,
                flags.uart0_rx | flags.uart0_tx,
                flags.tmr1,
                flags.ext1,
                flags.tmr0,
                flags.ext0};
  assign en_vec = pick(en_lo_q, en_hi_q);
  assign hi_vec = pick(lvl_lo_q, lvl_hi_q);

  //////////////////////////////////////////////////////////////////////////
  // Sample at each machine cycle start; the sample is replaced every cycle
  logic [N-1:0] sample_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sample_q <= '0;
    end else if (instr.cycle_start) begin
      sample_q <= req & en_vec;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Selection within each level
  function automatic logic [3:0] first_set(input logic [N-1:0] v);
    first_set = 4'd0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) first_set = 4'(i);
    end
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    unique case (s)
      4'd0:    vec_of = `VEC_EXT0;
      4'd1:    vec_of = `VEC_TMR0;
      4'd2:    vec_of = `VEC_EXT1;
      4'd3:    vec_of = `VEC_TMR1;
      4'd4:    vec_of = `VEC_UART0;
      4'd5:    vec_of = `VEC_TMR2;
      4'd6:    vec_of = `VEC_SPI;
      4'd7:    vec_of = `VEC_I2C;
      4'd8:    vec_of = `VEC_ADC;
      4'd9:    vec_of = `VEC_PCA;
      default: vec_of = `VEC_UART1;
    endcase
  endfunction

  logic         gate;
  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic         hi_ok;
  logic         lo_ok;
  logic         off_poll;
  logic         mid_instr;
  logic         ctrl_busy;
  logic         exit_busy;
  logic         blocked;
  logic         take;
  logic         take_hi;
  logic [3:0]   src;
  logic         exit_now;
  logic         inprog_hi_q;
  logic         inprog_lo_q;

  // Global gate masks every source at once
  assign gate    = en_lo_q[`EN_LO_GATE];
  assign hi_req  = gate ? (sample_q & hi_vec) : '0;
  assign lo_req  = gate ? (sample_q & ~hi_vec) : '0;

  // A level may start only while no handler of that level or above runs
  assign hi_ok   = |hi_req && !inprog_hi_q;
  assign lo_ok   = |lo_req && !inprog_hi_q && !inprog_lo_q;

  // Conditions that hold the hardware call off for this poll
  assign off_poll  = !instr.cycle_start;
  assign mid_instr = !instr.last_cycle;
  assign ctrl_busy = instr.ctrl_write || ctrl_wr_en;
  assign exit_busy = instr.exit_handler;
  assign blocked   = off_poll || mid_instr || ctrl_busy || exit_busy;

  // High level wins over low; polling order picks within the level
  assign take    = !blocked && (hi_ok || lo_ok);
  assign take_hi = hi_ok;
  assign src     = take_hi ? first_set(hi_req) : first_set(lo_req);

  // Handler exit completes on the final cycle of that instruction
  assign exit_now = instr.exit_handler && instr.last_cycle;

  //////////////////////////////////////////////////////////////////////////
  // Dispatch outputs, registered; the core pushes PC only and jumps
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dispatch <= '0;
    end else begin
      dispatch.call       <= take;
      dispatch.level_high <= take && take_hi;
      dispatch.source     <= take ? src : 4'd0;
      dispatch.vector     <= take ? vec_of(src) : 16'h0000;
    end
  end

  // Edge-mode external flag is cleared on entry; level mode is left alone
  function automatic logic entry_clear(input logic       call,
                                       input logic [3:0] s,
                                       input logic [3:0] idx,
                                       input logic       edge_mode);
    entry_clear = call && (s == idx) && edge_mode;
  endfunction

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext0_flag_clear <= 1'b0;
    end else begin
      ext0_flag_clear <= entry_clear(take, src, 4'd0, ext0_edge_mode);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext1_flag_clear <= 1'b0;
    end else begin
      ext1_flag_clear <= entry_clear(take, src, 4'd2, ext1_edge_mode);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // In-progress levels; only the handler exit instruction clears them
  // High level running; the first exit after a high call clears it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      inprog_hi_q <= 1'b0;
    end else if (take && take_hi) begin
      inprog_hi_q <= 1'b1;
    end else if (exit_now) begin
      inprog_hi_q <= 1'b0;
    end
  end

  // Low level running; an exit clears it only when no high handler runs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      inprog_lo_q <= 1'b0;
    end else if (take && !take_hi) begin
      inprog_lo_q <= 1'b1;
    end else if (exit_now && !inprog_hi_q) begin
      inprog_lo_q <= 1'b0;
    end
  end

  assign in_progress = {inprog_hi_q, inprog_lo_q};

endmodule // intc

// ### intc_pkg.sv
// Types shared by the interrupt controller and its surroundings
// Assumes: nothing beyond the constant header
package intc_pkg;

  // Raw flag inputs, one field per peripheral flag; each UART has an rx and a tx field
  typedef struct packed {
    logic ext0;
    logic tmr0;
    logic ext1;
    logic tmr1;
    logic uart0_rx;
    logic uart0_tx;
    logic tmr2;
    logic spi;
    logic i2c;
    logic adc;
    logic pca;
    logic uart1_rx;
    logic uart1_tx;
  } flag_in_t;

  // Instruction status from the core sequencer, one per machine cycle
  typedef struct packed {
    logic cycle_start;
    logic last_cycle;
    logic ctrl_write;
    logic exit_handler;
  } instr_stat_t;

  // Dispatch request towards the core
  typedef struct packed {
    logic        call;
    logic        level_high;
    logic [3:0]  source;
    logic [15:0] vector;
  } dispatch_t;

endpackage

// ### intc_regs.svh
// Constants for the two-level interrupt controller: bit positions, vectors
// Assumes: included by the package user and the controller module only
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

`define SRC_COUNT        11
// Bit positions in the low enable bank
`define EN_LO_EXT0       0
`define EN_LO_TMR0       1
`define EN_LO_EXT1       2
`define EN_LO_TMR1       3
`define EN_LO_UART0      4
`define EN_LO_TMR2       5
`define EN_LO_GATE       7
// Bit positions in the high enable / level bank
`define EN_HI_I2C        1
`define EN_HI_UART1      4
`define EN_HI_PCA        5
`define EN_HI_SPI        6
`define EN_HI_ADC        7
// Reset values of the four control bytes
`define EN_LO_RESET      8'h00
`define EN_HI_RESET      8'h00
`define LVL_LO_RESET     8'h00
`define LVL_HI_RESET     8'h00
// Vector addresses, indexed by polling position
`define VEC_EXT0         16'h0003
`define VEC_TMR0         16'h000B
`define VEC_EXT1         16'h0013
`define VEC_TMR1         16'h001B
`define VEC_UART0        16'h0023
`define VEC_TMR2         16'h002B
`define VEC_SPI          16'h0053
`define VEC_I2C          16'h0043
`define VEC_ADC          16'h003B
`define VEC_PCA          16'h005B
`define VEC_UART1        16'h004B

`endif

// ### intc_seq.sv
// Sequencer model: four-clock machine cycles, instruction status
// Assumes: requests come from the bench on the falling edge
module intc_seq (
  input  wire logic            core_clk,
  input  wire logic            rstn,
  input  wire logic            final_en,
  input  wire logic            wr_busy,
  input  wire logic            exit_req,
  output intc_pkg::instr_stat_t instr
);
  timeunit 1ns;
  timeprecision 1ps;
  import intc_pkg::*;
  logic [1:0] ph_q;
  always_ff @(negedge core_clk or negedge rstn) begin
    if (!rstn) ph_q <= 2'h0;
    else ph_q <= ph_q + 2'h1;
  end
  always_comb begin
    instr.cycle_start = rstn && ph_q == 2'h0;
    instr.last_cycle = final_en;
    instr.ctrl_write = wr_busy;
    instr.exit_handler = exit_req && rstn && ph_q == 2'h0;
  end
endmodule // intc_seq

// ### intc_sva.sv
// Checker: timing and gating relations of the dispatch port
// Assumes: bound to intc, one clock domain
module intc_sva (
  input wire logic                  core_clk,
  input wire logic                  rstn,
  input wire intc_pkg::instr_stat_t instr,
  input wire logic                  ctrl_wr_en,
  input wire intc_pkg::dispatch_t   dispatch,
  input wire logic                  ext0_flag_clear,
  input wire logic                  ext1_flag_clear,
  input wire logic [1:0]            in_progress
);
  timeunit 1ns;
  timeprecision 1ps;
  import intc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////
  property p_pulse; dispatch.call |=> !dispatch.call; endproperty
  a_pulse: assert property (p_pulse) else $error("long call");
  property p_start;
    dispatch.call |-> $past(instr.cycle_start && instr.last_cycle);
  endproperty
  a_start: assert property (p_start) else $error("bad poll");
  property p_wr;
    dispatch.call |-> !$past(instr.ctrl_write || ctrl_wr_en);
  endproperty
  a_wr: assert property (p_wr) else $error("call on write");
  property p_exit; dispatch.call |-> !$past(instr.exit_handler); endproperty
  a_exit: assert property (p_exit) else $error("call on exit");
  property p_lvl; dispatch.call |-> in_progress[dispatch.level_high];
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not set");
  property p_hold;
    dispatch.call |-> !$past(in_progress[1]) &&
      (dispatch.level_high || !$past(in_progress[0]));
  endproperty
  a_hold: assert property (p_hold) else $error("not held");
  property p_clr;
    ext0_flag_clear || ext1_flag_clear |-> dispatch.call &&
      dispatch.source == (ext0_flag_clear ? 4'h0 : 4'h2);
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_keep;
    $fell(in_progress[0]) || $fell(in_progress[1]) |->
      $past(instr.exit_handler && instr.last_cycle);
  endproperty
  a_keep: assert property (p_keep) else $error("bad exit");
  c_hi: cover property (dispatch.call && dispatch.level_high);
  c_nest: cover property (in_progress == 2'b11);
  c_clr: cover property (ext0_flag_clear);
endmodule // intc_sva

// ### intc_tb.sv
// Bench: random single, paired, nested and blocked interrupt traffic
// Assumes: intc, intc_seq and intc_sva compiled first
module intc_tb import intc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rstn = 1'b0, fe = 1'b1, wb = 1'b0, xr = 1'b0;
  logic em = 1'b0, we = 1'b0, c0, c1;
  logic [1:0] ws = 2'h0, ip;
  logic [7:0] wd = 8'h00, el, eh, ll, lh;
  flag_in_t fl = '0;
  instr_stat_t ins;
  dispatch_t dp, d;
  logic [1:0] c;
  int err_total = 0, compares = 0, a, b;
  logic [15:0] vt [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0023, 16'h002b, 16'h0053, 16'h0043, 16'h003b, 16'h005b, 16'h004b};
  intc_seq intc_seq_inst (.core_clk, .rstn, .final_en(fe), .wr_busy(wb),
    .exit_req(xr), .instr(ins));
  intc intc_inst (.core_clk, .rstn, .flags(fl), .ext0_edge_mode(em),
    .ext1_edge_mode(em), .instr(ins), .ctrl_wr_en(we), .ctrl_wr_sel(ws),
    .ctrl_wr_data(wd), .source_enable_low_bank(el),
    .source_enable_high_bank(eh), .level_select_low_bank(ll),
    .level_select_high_bank(lh), .dispatch(dp), .ext0_flag_clear(c0),
    .ext1_flag_clear(c1), .in_progress(ip));
  always #2.5 core_clk = ~core_clk;
  ////////////////////
  task automatic close_out;
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_d(dispatch_t g, dispatch_t e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_v(logic [7:0] g, logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Flag pattern for a polling index; a picks the second flag of a pair
  function automatic flag_in_t fb(int i, bit a);
    fb = '0;
    if (i < 4) fb[12 - i] = 1'b1;
    else if (i == 4) fb[a ? 7 : 8] = 1'b1;
    else if (i < 10) fb[11 - i] = 1'b1;
    else fb[a ? 0 : 1] = 1'b1;
  endfunction
  function automatic dispatch_t ex(int i, bit h);
    ex = '{1'b1, h, i[3:0], vt[i]};
  endfunction
  task automatic wt(bit need);
    d = '0;
    c = 2'b00;
    for (int n = 0; n < 40 && d.call !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
      if (dp.call === 1'b1) begin
        d = dp;
        c = {c0, c1};
      end
    end
    if (need && d.call !== 1'b1) begin
      err_total++;
      close_out;
    end
    @(negedge core_clk);
  endtask
  task automatic wr(logic [1:0] s, logic [7:0] v);
    @(negedge core_clk);
    we = 1'b1;
    ws = s;
    wd = v;
    @(negedge core_clk);
    we = 1'b0;
  endtask
  task automatic srv(int i, bit h, bit a);
    @(negedge core_clk);
    fl = fb(i, a);
    wt(1);
    chk_d(d, ex(i, h));
    chk_v({6'h00, c}, {6'h00, em && i == 0, em && i == 2});
    fl = '0;
  endtask
  task automatic ext(logic [1:0] e);
    xr = 1'b1;
    repeat (4) @(negedge core_clk);
    xr = 1'b0;
    repeat (2) @(negedge core_clk);
    chk_v({6'h00, ip}, {6'h00, e});
  endtask
  ////////////////////
  initial begin
    void'($urandom(32'hafe8_47e4));
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    chk_d(dp, '0);
    wr(2'h0, 8'hbf);
    wr(2'h1, 8'hf2);
    chk_v(el, 8'hbf);
    chk_v(eh, 8'hf2);
    for (int i = 0; i < 11; i++) begin
      em = (i == 0) | 1'($urandom);
      srv(i, 1'b0, 1'($urandom));
      ext(2'b00);
    end
    a = $urandom % 10;
    b = a + 1 + $urandom % (10 - a);
    fl = fb(a, 1'b0) | fb(b, 1'b1);
    wt(1);
    chk_d(d, ex(a, 1'b0));
    fl = '0;
    ext(2'b00);
    wr(2'h2, 8'h02);
    chk_v(ll, 8'h02);
    srv(3, 1'b0, 1'b0);
    fl = fb(5, 1'b0);
    wt(0);
    chk_d(d, '0);
    fl = fb(5, 1'b0) | fb(1, 1'b0);
    wt(1);
    chk_d(d, ex(1, 1'b1));
    fl = fb(5, 1'b0);
    ext(2'b01);
    wt(0);
    chk_d(d, '0);
    fl = '0;
    ext(2'b00);
    wr(2'h3, 8'h80);
    chk_v(lh, 8'h80);
    fl = fb(7, 1'b0) | fb(8, 1'b0);
    wt(1);
    chk_d(d, ex(8, 1'b1));
    fl = '0;
    ext(2'b00);
    for (int k = 0; k < 3; k++) begin
      fe = (k != 0);
      wb = (k == 1);
      xr = (k == 2);
      fl = fb(3, 1'b0);
      wt(0);
      chk_d(d, '0);
      fl = '0;
      repeat (8) @(negedge core_clk);
      fe = 1'b1;
      wb = 1'b0;
      xr = 1'b0;
      wt(0);
      chk_d(d, '0);
    end
    wr(2'h0, 8'h3f);
    fl = fb(0, 1'b0);
    wt(0);
    chk_d(d, '0);
    close_out;
  end
endmodule // intc_tb
bind intc intc_sva intc_sva_inst (.core_clk, .rstn, .instr, .ctrl_wr_en,
  .dispatch, .ext0_flag_clear, .ext1_flag_clear, .in_progress);
